//--- core/asrb_pkg.sv
// Purpose: Shared constants and carriers for the arming and status register bank
// Assumes: Byte-wide register port with 8-bit addresses
// Notes: Offsets are the register addresses as the host sees them
package asrb_pkg;
  localparam logic [7:0] ARMING_SETUP_OFFSET = 8'h0e;
  localparam logic [7:0] POS_THRESH_OFFSET = 8'h10;
  localparam logic [7:0] NEG_THRESH_OFFSET = 8'h12;
  localparam logic [7:0] COND_FLAGS_OFFSET = 8'h14;
  localparam logic [7:0] TICK_COUNT_OFFSET = 8'h15;
  localparam logic [7:0] TRIM_READ_OFFSET = 8'h16;
  localparam logic [7:0] SPARE_A_OFFSET = 8'h1c;
  localparam logic [7:0] SPARE_B_OFFSET = 8'h1d;

  localparam int POS_WS_LSB = 0;
  localparam int NEG_WS_LSB = 2;
  localparam int PULSE_STRETCH_LSB = 4;
  localparam logic [7:0] ARMING_SETUP_RESET = 8'h0f;
  localparam logic [7:0] ARMING_SETUP_MASK = 8'h3f;
  localparam logic [7:0] THRESH_RESET = 8'h00;

  localparam int FLAG_DATA_FAULT = 6;
  localparam int FLAG_MOD_OVER = 5;
  localparam int FLAG_INIT_BUSY = 4;
  localparam int FLAG_MISO_MISMATCH = 3;
  localparam int FLAG_ZERO_BIT = 2;
  localparam int FLAG_OFFSET_OVER = 1;
  localparam int FLAG_RESET_SEEN = 0;
  localparam logic [7:0] STICKY_MASK = 8'h6b;

  localparam int PRESCALE_BITS = 10;
  localparam logic [PRESCALE_BITS-1:0] PRESCALE_LAST = 10'h3ff;
  localparam logic [7:0] TICK_RESET = 8'h00;

  typedef enum logic [2:0]
  {
    ASRB_ARM_OFF = 3'h0,
    ASRB_ARM_PCM = 3'h1,
    ASRB_ARM_AVG_HI = 3'h2,
    ASRB_ARM_AVG_LO = 3'h3,
    ASRB_ARM_CNT_HI = 3'h4,
    ASRB_ARM_CNT_LO = 3'h5,
    ASRB_ARM_RAW_HI = 3'h6,
    ASRB_ARM_RAW_LO = 3'h7
  } asrb_arm_mode_e;

  typedef struct packed
  {
    logic data_fault;
    logic data_fault_persist;
    logic modulator_overrange;
    logic miso_mismatch;
    logic offset_overrange;
  } asrb_events_s;

  typedef struct packed
  {
    logic enable;
    logic positive_enable;
    logic negative_enable;
    logic use_average;
    logic use_count;
    logic use_pcm;
    logic active_low;
    logic [4:0] positive_window;
    logic [4:0] negative_window;
    logic [3:0] count_limit;
    logic [1:0] pulse_stretch;
  } asrb_arm_ctrl_s;
endpackage

//--- core/asrb_arm_decode.sv
// Purpose: Turns the arming mode, window codes and thresholds into datapath controls
// Assumes: Inputs come from registers on the same clock
// Notes: Pure decode; the owner registers the result
`timescale 1ns/1ns
module asrb_arm_decode
(
  input wire logic [2:0] mode_in,
  input wire logic [7:0] setup_in,
  input wire logic [7:0] pos_thresh_in,
  input wire logic [7:0] neg_thresh_in,
  output wire asrb_pkg::asrb_arm_ctrl_s ctrl_out
);
  wire logic [1:0] pos_code;
  wire logic [1:0] neg_code;
  wire logic pos_live;
  wire logic neg_live;
  wire logic any_live;
  wire asrb_pkg::asrb_arm_mode_e mode;

  assign mode = asrb_pkg::asrb_arm_mode_e'(mode_in);
  assign pos_code = setup_in[asrb_pkg::POS_WS_LSB +: 2];
  assign neg_code = setup_in[asrb_pkg::NEG_WS_LSB +: 2];
  // A zero threshold silences only its own polarity
  assign pos_live = (pos_thresh_in != 8'h00); // [R6]
  assign neg_live = (neg_thresh_in != 8'h00); // [R6]
  // Both zero overrides whatever mode is programmed
  assign any_live = pos_live | neg_live; // [R7]

  assign ctrl_out.enable = any_live && (mode != asrb_pkg::ASRB_ARM_OFF); // [R7] [R20]
  assign ctrl_out.positive_enable = pos_live; // [R6]
  assign ctrl_out.negative_enable = neg_live; // [R6]
  assign ctrl_out.use_pcm = (mode == asrb_pkg::ASRB_ARM_PCM); // [R20]
  assign ctrl_out.use_average = (mode_in[2:1] == 2'h1); // [R20]
  assign ctrl_out.use_count = (mode_in[2:1] == 2'h2); // [R20]
  assign ctrl_out.active_low = mode_in[0] && (mode_in[2:1] != 2'h0); // [R20]
  // Window lengths 2,4,8,16 taken per polarity
  assign ctrl_out.positive_window = 5'h02 << pos_code; // [R1]
  assign ctrl_out.negative_window = 5'h02 << neg_code; // [R1]
  // Count limits 1,3,7,15 from the positive field alone
  assign ctrl_out.count_limit = 4'((5'h02 << pos_code) - 5'h01); // [R2]
  assign ctrl_out.pulse_stretch = setup_in[asrb_pkg::PULSE_STRETCH_LSB +: 2];
endmodule

//--- core/asrb_regs.sv
// Purpose: Host-visible arming thresholds, status flags, oscillator monitor and trim readback
// Assumes: Byte register port from the serial front end, single clock, sync reset
// Notes: Reads return data one cycle after the strobe
//
// Function
// R1: moving-average window 2..16 per polarity
// R2: count limit 1,3,7,15 from positive field
// R3: thresholds writable only before init lock
// R4: thresholds feed writable-array checksum
// R5: thresholds are unsigned 8-bit magnitudes
// R6: zero threshold disables that polarity only
// R7: both zero disables arming and pin
// R8: status read-only, read clears transient flags
// R9: bit 6 internal data fault, read-clear
// R10: checksum fault reasserts; fuse fault survives reset
// R11: bit 5 modulator over-range, read-clear
// R12: bit 4 init busy, self-clearing, read-immune
// R13: bit 3 serial output mismatch, read-clear
// R14: bit 1 offset over-range, read-clear
// R15: bit 0 reset-occurred, read-clear
// R16: bit 7 unused, bit 2 reads zero
// R17: free-running counter, oscillator divided 1024
// R18: offset correction readback register
// R19: host writes zeros to spare locations
// R20: three-bit arming mode decode
// R21: window fields in setup, reset ones
// R22: read and clear in one step
`timescale 1ns/1ns
module asrb_regs
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic init_complete_lock_in,
  input wire logic init_done_in,
  input wire logic [2:0] arm_mode_in,
  input wire asrb_pkg::asrb_events_s events_in,
  input wire logic fuse_fault_in,
  input wire logic [7:0] offset_step_in,
  input wire logic offset_step_valid_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output asrb_pkg::asrb_arm_ctrl_s arm_ctrl_out,
  output logic [7:0] positive_threshold_value_out,
  output logic [7:0] negative_threshold_value_out,
  output logic [7:0] arming_setup_out,
  output logic [7:0] spare_a_out,
  output logic [7:0] spare_b_out
);
  logic [7:0] positive_arm_threshold;
  logic [7:0] negative_arm_threshold;
  logic [7:0] arming_setup_register;
  logic [7:0] spare_location_a;
  logic [7:0] spare_location_b;
  logic [7:0] offset_trim_readback;
  logic [asrb_pkg::PRESCALE_BITS-1:0] prescale;
  logic [7:0] oscillator_tick_counter;
  logic [7:0] sticky;
  logic init_in_progress_flag;
  logic csum_fault_latched;
  logic [7:0] read_data;
  asrb_pkg::asrb_arm_ctrl_s arm_ctrl;
  logic [7:0] next_sticky;

  wire logic hit_setup = reg_addr_in == asrb_pkg::ARMING_SETUP_OFFSET;
  wire logic hit_pos = reg_addr_in == asrb_pkg::POS_THRESH_OFFSET;
  wire logic hit_neg = reg_addr_in == asrb_pkg::NEG_THRESH_OFFSET;
  wire logic hit_flags = reg_addr_in == asrb_pkg::COND_FLAGS_OFFSET;
  wire logic hit_tick = reg_addr_in == asrb_pkg::TICK_COUNT_OFFSET;
  wire logic hit_trim = reg_addr_in == asrb_pkg::TRIM_READ_OFFSET;
  wire logic hit_spare_a = reg_addr_in == asrb_pkg::SPARE_A_OFFSET;
  wire logic hit_spare_b = reg_addr_in == asrb_pkg::SPARE_B_OFFSET;
  // Lock closes all initialization-time writes at once
  wire logic write_open = reg_write_in && !init_complete_lock_in; // [R3]
  wire logic flags_read = reg_read_in && hit_flags; // [R8]
  wire logic prescale_wrap = prescale == asrb_pkg::PRESCALE_LAST; // [R17]

  // Writable-array fault keeps re-raising until reset; fuse faults arrive again after reset
  wire logic fault_source = events_in.data_fault || csum_fault_latched || fuse_fault_in; // [R9] [R10]

  wire logic [7:0] event_bits;
  assign event_bits[7] = 1'b0;
  assign event_bits[asrb_pkg::FLAG_DATA_FAULT] = fault_source; // [R9]
  assign event_bits[asrb_pkg::FLAG_MOD_OVER] = events_in.modulator_overrange; // [R11]
  assign event_bits[asrb_pkg::FLAG_INIT_BUSY] = 1'b0;
  assign event_bits[asrb_pkg::FLAG_MISO_MISMATCH] = events_in.miso_mismatch; // [R13]
  assign event_bits[asrb_pkg::FLAG_ZERO_BIT] = 1'b0;
  assign event_bits[asrb_pkg::FLAG_OFFSET_OVER] = events_in.offset_overrange; // [R14]
  assign event_bits[asrb_pkg::FLAG_RESET_SEEN] = 1'b0;

  // A flag raised in the read cycle survives the clear
  assign next_sticky = ((sticky & ~(flags_read ? asrb_pkg::STICKY_MASK : 8'h00)) | event_bits)
                       & asrb_pkg::STICKY_MASK; // [R8] [R22]

  wire logic [7:0] flags_view = {1'b0, sticky[6:5], init_in_progress_flag, sticky[3], 1'b0, sticky[1:0]}; // [R12] [R16]

  assign read_data = hit_setup ? arming_setup_register :
                     hit_pos ? positive_arm_threshold :
                     hit_neg ? negative_arm_threshold :
                     hit_flags ? flags_view :
                     hit_tick ? oscillator_tick_counter :
                     hit_trim ? offset_trim_readback :
                     hit_spare_a ? spare_location_a :
                     hit_spare_b ? spare_location_b : 8'h00;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      positive_arm_threshold <= asrb_pkg::THRESH_RESET;
      negative_arm_threshold <= asrb_pkg::THRESH_RESET;
      arming_setup_register <= asrb_pkg::ARMING_SETUP_RESET; // [R21]
      spare_location_a <= 8'h00;
      spare_location_b <= 8'h00;
    end
    else
    begin
      if (write_open && hit_pos)
      begin
        positive_arm_threshold <= reg_wdata_in; // [R3] [R5]
      end
      if (write_open && hit_neg)
      begin
        negative_arm_threshold <= reg_wdata_in; // [R3] [R5]
      end
      if (write_open && hit_setup)
      begin
        arming_setup_register <= reg_wdata_in & asrb_pkg::ARMING_SETUP_MASK; // [R21]
      end
      // Spares are stored as written; the host keeps them at zero
      if (write_open && hit_spare_a)
      begin
        spare_location_a <= reg_wdata_in; // [R19]
      end
      if (write_open && hit_spare_b)
      begin
        spare_location_b <= reg_wdata_in; // [R19]
      end
    end
  end

  // Status flags: reset-seen is raised by the reset itself and lasts until read
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sticky <= 8'h01; // [R15]
      init_in_progress_flag <= 1'b1; // [R12]
      csum_fault_latched <= 1'b0;
    end
    else
    begin
      sticky <= next_sticky;
      if (init_done_in)
      begin
        init_in_progress_flag <= 1'b0; // [R12]
      end
      if (events_in.data_fault_persist)
      begin
        csum_fault_latched <= 1'b1; // [R10]
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prescale <= '0;
      oscillator_tick_counter <= asrb_pkg::TICK_RESET;
    end
    else
    begin
      prescale <= prescale + {{(asrb_pkg::PRESCALE_BITS-1){1'b0}}, 1'b1}; // [R17]
      if (prescale_wrap)
      begin
        oscillator_tick_counter <= oscillator_tick_counter + 8'h01; // [R17]
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      offset_trim_readback <= 8'h00;
    end
    else if (offset_step_valid_in)
    begin
      offset_trim_readback <= offset_step_in; // [R18]
    end
  end

  asrb_arm_decode u_decode
  (
    .mode_in(arm_mode_in),
    .setup_in(arming_setup_register),
    .pos_thresh_in(positive_arm_threshold),
    .neg_thresh_in(negative_arm_threshold),
    .ctrl_out(arm_ctrl)
  );

  // All outputs registered; thresholds and setup also leave for the checksum engine
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
      arm_ctrl_out <= '0;
      positive_threshold_value_out <= asrb_pkg::THRESH_RESET;
      negative_threshold_value_out <= asrb_pkg::THRESH_RESET;
      arming_setup_out <= asrb_pkg::ARMING_SETUP_RESET;
      spare_a_out <= 8'h00;
      spare_b_out <= 8'h00;
    end
    else
    begin
      reg_rdata_out <= reg_read_in ? read_data : 8'h00;
      reg_rvalid_out <= reg_read_in;
      arm_ctrl_out <= arm_ctrl; // [R1] [R2] [R6] [R7]
      positive_threshold_value_out <= positive_arm_threshold; // [R4]
      negative_threshold_value_out <= negative_arm_threshold; // [R4]
      arming_setup_out <= arming_setup_register;
      spare_a_out <= spare_location_a;
      spare_b_out <= spare_location_b;
    end
  end
endmodule

//--- tb/asrb_checker.sv
// Purpose: Port-level properties of the register bank
// Assumes: One clock, sync active-high reset
// Notes: Bound to every asrb_regs instance
`timescale 1ns/1ns
module asrb_checker
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic init_complete_lock_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire asrb_pkg::asrb_arm_ctrl_s arm_ctrl_out,
  input wire logic [7:0] positive_threshold_value_out,
  input wire logic [7:0] negative_threshold_value_out,
  input wire logic [7:0] arming_setup_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_read_answer: assert property (reg_read_in |=> reg_rvalid_out) else $error("read not answered");
  chk_zero_bit: assert property (reg_rvalid_out && $past(reg_addr_in) == asrb_pkg::COND_FLAGS_OFFSET
    |-> !reg_rdata_out[2]) else $error("flag bit 2 set");
  chk_lock_hold: assert property (init_complete_lock_in && reg_write_in |=> ##1
    $stable(positive_threshold_value_out) && $stable(negative_threshold_value_out)) else $error("locked write took");
  chk_thr_take: assert property (!init_complete_lock_in && reg_write_in
    && reg_addr_in == asrb_pkg::POS_THRESH_OFFSET |-> ##2 positive_threshold_value_out == $past(reg_wdata_in, 2))
    else $error("threshold copy wrong");
  chk_both_zero: assert property (positive_threshold_value_out == 8'h00
    && negative_threshold_value_out == 8'h00 |-> !arm_ctrl_out.enable) else $error("armed with zero thresholds");
  chk_pos_zero: assert property (positive_threshold_value_out == 8'h00
    |-> !arm_ctrl_out.positive_enable) else $error("zero polarity enabled");
  chk_avg_window: assert property (arm_ctrl_out.use_average
    |-> arm_ctrl_out.positive_window == 5'h02 << arming_setup_out[1:0]) else $error("window wrong");
  chk_count_limit: assert property (arm_ctrl_out.use_count
    |-> arm_ctrl_out.count_limit == (4'h2 << arming_setup_out[1:0]) - 4'h1) else $error("count limit wrong");
  cover property (reg_rvalid_out && reg_rdata_out[6]);
  cover property (arm_ctrl_out.use_count);
  cover property (init_complete_lock_in && reg_write_in);
endmodule

bind asrb_regs asrb_checker chk (.clk_in, .reset_in, .reg_write_in, .reg_read_in, .reg_addr_in, .reg_wdata_in,
  .init_complete_lock_in, .reg_rdata_out, .reg_rvalid_out, .arm_ctrl_out, .positive_threshold_value_out,
  .negative_threshold_value_out, .arming_setup_out);

//--- tb/asrb_host.sv
// Purpose: Host model issuing register strobes
// Assumes: Bench calls its tasks; strobes change at the falling edge
// Notes: Released address shows the inverse of the last value; write data is inverted only when a write releases
`timescale 1ns/1ns
module asrb_host
(
  input wire logic clk_in,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] reg_rdata_out,
  output logic reg_write_in = 1'b0,
  output logic reg_read_in = 1'b0,
  output logic [7:0] reg_addr_in = 8'h00,
  output logic [7:0] reg_wdata_in = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = (a == asrb_pkg::SPARE_A_OFFSET || a == asrb_pkg::SPARE_B_OFFSET) ? 8'h00 : d;
    @(negedge clk_in);
    reg_write_in = 1'b0;
    reg_addr_in = ~reg_addr_in;
    reg_wdata_in = ~reg_wdata_in;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(negedge clk_in);
    reg_read_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_in);
    r = {reg_rvalid_out, reg_rdata_out};
    reg_read_in = 1'b0;
    reg_addr_in = ~reg_addr_in;
  endtask
endmodule

//--- tb/arming_status_register_bank_test.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Host model drives the register port
// Notes: Flag bit 7 is masked though the bank always reads it as zero
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) \
  begin n_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module arming_status_register_bank_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic init_complete_lock_in = 1'b0, init_done_in = 1'b0, fuse_fault_in = 1'b0, offset_step_valid_in = 1'b0;
  logic [2:0] arm_mode_in = 3'h0;
  logic [7:0] offset_step_in = 8'h00;
  asrb_pkg::asrb_events_s events_in = '0;
  wire logic reg_write_in, reg_read_in, reg_rvalid_out;
  wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  asrb_pkg::asrb_arm_ctrl_s arm_ctrl_out;
  logic [7:0] positive_threshold_value_out, negative_threshold_value_out, arming_setup_out, spare_a_out, spare_b_out;
  logic [8:0] r, q;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk_in = ~clk_in;
  asrb_host host (.clk_in, .reg_rvalid_out, .reg_rdata_out, .reg_write_in, .reg_read_in, .reg_addr_in, .reg_wdata_in);
  asrb_regs uut (.clk_in, .reset_in, .reg_write_in, .reg_read_in, .reg_addr_in, .reg_wdata_in, .init_complete_lock_in,
    .init_done_in, .arm_mode_in, .events_in, .fuse_fault_in, .offset_step_in, .offset_step_valid_in, .reg_rdata_out,
    .reg_rvalid_out, .arm_ctrl_out, .positive_threshold_value_out, .negative_threshold_value_out, .arming_setup_out,
    .spare_a_out, .spare_b_out);
  task automatic pulse(input logic [4:0] s);
    @(negedge clk_in);
    events_in = s;
    @(negedge clk_in);
    events_in = '0;
  endtask
  task automatic t_reset();
    host.rd(asrb_pkg::ARMING_SETUP_OFFSET, r);
    `CHK("setup", 9'h10f, r)
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("flags", 9'h111, r & 9'h17f)
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("busy", 9'h110, r & 9'h17f)
    host.rd(8'h40, r);
    `CHK("unmapped", 9'h100, r)
    host.wr(asrb_pkg::SPARE_A_OFFSET, 8'h5a);
    host.rd(asrb_pkg::SPARE_A_OFFSET, r);
    `CHK("spare", 25'h1000000, {r, spare_a_out, spare_b_out})
  endtask
  task automatic t_events();
    logic [4:0] src [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
    logic [7:0] flg [4] = '{8'h40, 8'h20, 8'h08, 8'h02};
    init_done_in = 1'b1;
    host.wr(asrb_pkg::COND_FLAGS_OFFSET, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      pulse(src[i]);
      host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
      `CHK("set", {1'b1, flg[i]}, r & 9'h17f)
      host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
      `CHK("clear", 9'h100, r & 9'h17f)
    end
    fork
      host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
      pulse(5'h04);
    join
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("kept", 9'h120, r & 9'h17f)
    pulse(5'h08);
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("persist", 9'h140, r & 9'h17f)
    fuse_fault_in = 1'b1;
    init_done_in = 1'b0;
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("fuse", 9'h151, r & 9'h17f)
    fuse_fault_in = 1'b0;
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    host.rd(asrb_pkg::COND_FLAGS_OFFSET, r);
    `CHK("reset clears", 9'h110, r & 9'h17f)
  endtask
  task automatic t_arm();
    logic [2:0] m;
    logic [6:0] got;
    logic [9:0] win;
    arm_mode_in = 3'h6;
    repeat (2) @(negedge clk_in);
    `CHK("off", 1'b0, arm_ctrl_out.enable)
    host.wr(asrb_pkg::POS_THRESH_OFFSET, 8'h05);
    for (int c = 0; c < 4; c++)
    begin
      host.wr(asrb_pkg::ARMING_SETUP_OFFSET, {2'h0, 2'(c), 2'(3 - c), 2'(c)});
      for (int k = 0; k < 8; k++)
      begin
        m = 3'(k);
        arm_mode_in = m;
        repeat (2) @(negedge clk_in);
        got = {arm_ctrl_out.enable, arm_ctrl_out.positive_enable, arm_ctrl_out.negative_enable, arm_ctrl_out.use_pcm,
          arm_ctrl_out.use_average, arm_ctrl_out.use_count, arm_ctrl_out.active_low};
        win = {arm_ctrl_out.positive_window, arm_ctrl_out.negative_window};
        `CHK("mode", {m != 0, 1'b1, 1'b0, m == 1, m[2:1] == 1, m[2:1] == 2, m[0] && m[2:1] != 0}, got)
        if (m[2:1] == 1) `CHK("avg", {5'h02 << c, 5'h02 << (3 - c)}, win)
        if (m[2:1] == 2) `CHK("cnt", (4'h2 << c) - 4'h1, arm_ctrl_out.count_limit)
      end
      `CHK("setup copy", {2'h0, 2'(c), 2'(3 - c), 2'(c), 2'(c)}, {arming_setup_out, arm_ctrl_out.pulse_stretch})
    end
  endtask
  task automatic t_lock_trim();
    host.wr(asrb_pkg::NEG_THRESH_OFFSET, 8'hff);
    init_complete_lock_in = 1'b1;
    host.wr(asrb_pkg::POS_THRESH_OFFSET, 8'h33);
    host.rd(asrb_pkg::POS_THRESH_OFFSET, r);
    `CHK("locked", 9'h105, r)
    `CHK("crc copy", 16'h05ff, {positive_threshold_value_out, negative_threshold_value_out})
    offset_step_in = 8'hfd;
    offset_step_valid_in = 1'b1;
    @(negedge clk_in);
    offset_step_valid_in = 1'b0;
    offset_step_in = 8'h02;
    host.rd(asrb_pkg::TRIM_READ_OFFSET, r);
    `CHK("trim", 9'h1fd, r)
    host.rd(asrb_pkg::TICK_COUNT_OFFSET, q);
    repeat (1022) @(negedge clk_in);
    host.rd(asrb_pkg::TICK_COUNT_OFFSET, r);
    `CHK("tick", {1'b1, q[7:0] + 8'h01}, r)
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge clk_in);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    t_reset();
    t_events();
    t_arm();
    t_lock_trim();
    print_verdict();
  end
endmodule
